// ==== logic/sdm_regs.vh ====
/*
  Register offsets, field positions, reset values and codes for the sideband
  drive and monitor select block. Assumes a 32-bit Avalon-MM master with
  byte addressing and word-aligned accesses.
*/
// What this block does
// [RULE_01] Monitor enabled: selected sideband level drives trigger line.
// [RULE_02] Outside equipment leaves a monitored trigger line undriven.
// [RULE_03] Only nine sideband signals, host or drive, monitorable.
// [RULE_04] Value-returning queries accept single signals, reject groups.
// [RULE_05] All-signals group sets every switched signal.
// [RULE_06] Lane groups zero to three select lane signals.
// [RULE_07] Power group selects supplies; data group selects lanes.
// [RULE_08] Management group selects all management interface signals.
// [RULE_09] First port: lanes 0-1, first clock, first reset.
// [RULE_10] Second port: lanes 2-3, second clock, second reset.
// [RULE_11] First data group: lanes 0 and 1 only.
// [RULE_12] Second data group: lanes 2 and 3 only.
// [RULE_13] Presence low request pulls host low; drive never.
// [RULE_14] Sideband reset: host never driven; drive follows level.
// [RULE_15] Dual-port, power disable, first reset: drive side only.
// [RULE_16] Shared second reset: only drive-side low is driven.
// [RULE_17] Indicator low request pulls host low; drive never.
// [RULE_18] Separate open and closed drive settings per pin.
// [RULE_19] Trigger monitor active only in sideband monitor mode.
// [RULE_20] Group setting updates all members in one cycle.
`ifndef SDM_REGS_VH
`define SDM_REGS_VH

`define SDM_ADDR_SW_STATE   8'h00
`define SDM_ADDR_SW_CMD     8'h04
`define SDM_ADDR_DRV_CMD    8'h08
`define SDM_ADDR_QSEL       8'h0c
`define SDM_ADDR_QDATA      8'h10
`define SDM_ADDR_TRIG_CFG   8'h14
`define SDM_ADDR_STATUS     8'h18

`define SDM_ID_ALL          6'h20
`define SDM_ID_LANE0        6'h21
`define SDM_ID_POWER        6'h25
`define SDM_ID_DATA         6'h26
`define SDM_ID_SBUS         6'h27
`define SDM_ID_CLK_A        6'h28
`define SDM_ID_CLK_B        6'h29
`define SDM_ID_MGMT         6'h2a
`define SDM_ID_PORT_A       6'h2b
`define SDM_ID_PORT_B       6'h2c
`define SDM_ID_DATA_A       6'h2d
`define SDM_ID_DATA_B       6'h2e
`define SDM_ID_SB_BASE      6'h16

`define SDM_DRV_NONE        2'h0
`define SDM_DRV_HIGH        2'h1
`define SDM_DRV_LOW         2'h2

`define SDM_MODE_OFF        2'h0
`define SDM_MODE_SIDEBAND   2'h3

`define SDM_SB_PRESENCE     4'h0
`define SDM_SB_PORT0_RST    4'h1
`define SDM_SB_RST1_CLKREQ  4'h2
`define SDM_SB_BUS_RST      4'h3
`define SDM_SB_INDICATOR    4'h6
`define SDM_SB_PWR_DIS      4'h7
`define SDM_SB_DUAL_EN      4'h8
`define SDM_SB_LAST         4'h8

`define SDM_SW_RESET        32'h00000000
`define SDM_TRIG_RESET      15'h0000

`endif

// ==== logic/sdm_select.v ====
/*
  Sideband drive and monitor select block: resolves signal and group names
  into switch sets, holds per-pin drive settings, and routes a chosen
  sideband level onto the trigger in or trigger out connector.
  Assumes a 32-bit Avalon-MM master on the same clock, and pin levels that
  are already synchronous to the clock.
*/
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`include "sdm_regs.vh"

module sdm_select #(
  parameter MON_SUPPORTED = 1
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [8:0]  host_sb_level,
  input  wire [8:0]  drive_sb_level,
  output reg  [31:0] switch_closed,
  output reg  [8:0]  host_drv_o,
  output reg  [8:0]  host_drv_oe,
  output reg  [8:0]  drive_drv_o,
  output reg  [8:0]  drive_drv_oe,
  output reg         trig_in_o,
  output reg         trig_in_oe,
  output reg         trig_out_o,
  output reg         trig_out_oe
);

  // Signal ids: 0..15 lane pins (4 per lane), 16..17 supplies, 18..21 clocks,
  // 22..30 the nine sideband signals in monitor order, 31 manufacturing pin.
  function [31:0] member_mask;
    input [5:0] id;
    begin
      member_mask = 32'h00000000;
      if (id < `SDM_ID_ALL)
        member_mask = 32'h00000001 << id;
      else case (id)
        `SDM_ID_ALL:       member_mask = 32'hffffffff; // RULE_05
        6'h21:             member_mask = 32'h0000000f; // RULE_06
        6'h22:             member_mask = 32'h000000f0; // RULE_06
        6'h23:             member_mask = 32'h00000f00; // RULE_06
        6'h24:             member_mask = 32'h0000f000; // RULE_06
        `SDM_ID_POWER:     member_mask = 32'h00030000; // RULE_07
        `SDM_ID_DATA:      member_mask = 32'h0000ffff; // RULE_07
        `SDM_ID_SBUS:      member_mask = 32'h0e000000;
        `SDM_ID_CLK_A:     member_mask = 32'h000c0000;
        `SDM_ID_CLK_B:     member_mask = 32'h00300000;
        `SDM_ID_MGMT:      member_mask = 32'h8e000000; // RULE_08
        `SDM_ID_PORT_A:    member_mask = 32'h008c00ff; // RULE_09
        `SDM_ID_PORT_B:    member_mask = 32'h0130ff00; // RULE_10
        `SDM_ID_DATA_A:    member_mask = 32'h000000ff; // RULE_11
        `SDM_ID_DATA_B:    member_mask = 32'h0000ff00; // RULE_12
        default:           member_mask = 32'h00000000;
      endcase
    end
  endfunction

  // A single sideband id maps to its monitor index; others give 4'hf.
  function [3:0] sb_index;
    input [5:0] id;
    reg   [5:0] off;
    begin
      off = id - `SDM_ID_SB_BASE;
      if (id >= `SDM_ID_SB_BASE && off <= {2'b00, `SDM_SB_LAST})
        sb_index = off[3:0];
      else
        sb_index = 4'hf;
    end
  endfunction

  function drive_capable;
    input [3:0] sb;
    begin
      drive_capable = (sb <= `SDM_SB_LAST) && (sb != 4'h4) && (sb != 4'h5);
    end
  endfunction

  // Returns {host_oe, host_o, drive_oe, drive_o} for a pin and request.
  function [3:0] drive_map;
    input [3:0] sb;
    input [1:0] req;
    begin
      drive_map = 4'h0;
      case (sb)
        `SDM_SB_PRESENCE, `SDM_SB_INDICATOR:
          if (req == `SDM_DRV_LOW) drive_map = 4'b1000; // RULE_13 RULE_17
        `SDM_SB_BUS_RST, `SDM_SB_PORT0_RST, `SDM_SB_PWR_DIS, `SDM_SB_DUAL_EN: begin
          if (req == `SDM_DRV_HIGH) drive_map = 4'b0011; // RULE_14 RULE_15
          if (req == `SDM_DRV_LOW) drive_map = 4'b0010; // RULE_14 RULE_15
        end
        `SDM_SB_RST1_CLKREQ:
          if (req == `SDM_DRV_LOW) drive_map = 4'b0010; // RULE_16
        default: drive_map = 4'h0;
      endcase
    end
  endfunction

  reg  [1:0]  open_mode_reg [0:8];
  reg  [1:0]  closed_mode_reg [0:8];
  reg  [5:0]  qsel_reg;
  reg  [14:0] trig_cfg_reg;
  reg         err_reg;
  reg         ack_reg;
  reg  [31:0] rd_next;
  reg         err_set;
  reg  [3:0]  dmap;
  reg  [1:0]  req_mode;
  reg  [8:0]  host_oe_next;
  reg  [8:0]  host_o_next;
  reg  [8:0]  drive_oe_next;
  reg  [8:0]  drive_o_next;
  integer     i;
  integer     j;

  wire        req      = avs_read | avs_write;
  wire        wr_fire  = avs_write & ack_reg;
  // Read data are loaded at the first edge of a read, so that they already
  // stand in the cycle in which waitrequest is low and the master takes them.
  wire        rd_fire  = avs_read & ~ack_reg;
  wire [5:0]  wr_id    = avs_writedata[5:0];
  wire [31:0] wr_mask  = member_mask(wr_id);
  wire [3:0]  wr_sb    = sb_index(wr_id);
  wire [3:0]  q_sb     = sb_index(qsel_reg);
  wire        q_single = (qsel_reg < `SDM_ID_ALL);
  wire [1:0]  tin_mode  = trig_cfg_reg[1:0];
  wire [3:0]  tin_sel   = trig_cfg_reg[5:2];
  wire        tin_side  = trig_cfg_reg[6];
  wire [1:0]  tout_mode = trig_cfg_reg[9:8];
  wire [3:0]  tout_sel  = trig_cfg_reg[13:10];
  wire        tout_side = trig_cfg_reg[14];
  wire        tin_mon  = (MON_SUPPORTED != 0) && (tin_mode == `SDM_MODE_SIDEBAND); // RULE_19
  wire        tout_mon = (MON_SUPPORTED != 0) && (tout_mode == `SDM_MODE_SIDEBAND); // RULE_19
  wire        trig_ok  = (avs_writedata[5:2] <= `SDM_SB_LAST) &&
                         (avs_writedata[13:10] <= `SDM_SB_LAST); // RULE_03

  // Each access is answered one cycle after it appears.
  assign avs_waitrequest = req & ~ack_reg;

  always @(posedge clock or posedge rst) begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= req & ~ack_reg;
  end

  // The whole member set of a group is written in the same edge.
  always @(posedge clock or posedge rst) begin
    if (rst)
      switch_closed <= `SDM_SW_RESET;
    else if (wr_fire && avs_address == `SDM_ADDR_SW_CMD && wr_mask != 32'h00000000) begin
      if (avs_writedata[8])
        switch_closed <= switch_closed | wr_mask; // RULE_20
      else
        switch_closed <= switch_closed & ~wr_mask; // RULE_20
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 9; i = i + 1) begin
        open_mode_reg[i]   <= `SDM_DRV_NONE;
        closed_mode_reg[i] <= `SDM_DRV_NONE;
      end
    end else if (wr_fire && avs_address == `SDM_ADDR_DRV_CMD && drive_capable(wr_sb)) begin
      open_mode_reg[wr_sb]   <= avs_writedata[9:8]; // RULE_18
      closed_mode_reg[wr_sb] <= avs_writedata[11:10]; // RULE_18
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      qsel_reg     <= 6'h00;
      trig_cfg_reg <= `SDM_TRIG_RESET;
    end else if (wr_fire) begin
      if (avs_address == `SDM_ADDR_QSEL && wr_id < `SDM_ID_ALL)
        qsel_reg <= wr_id; // RULE_04
      if (avs_address == `SDM_ADDR_TRIG_CFG && trig_ok)
        trig_cfg_reg <= avs_writedata[14:0];
    end
  end

  // Any refused command sets the sticky error; a new error wins over clear.
  always @* begin
    err_set = 1'b0;
    if (wr_fire) begin
      case (avs_address)
        `SDM_ADDR_SW_CMD:   err_set = (wr_mask == 32'h00000000);
        `SDM_ADDR_DRV_CMD:  err_set = ~drive_capable(wr_sb);
        `SDM_ADDR_QSEL:     err_set = (wr_id >= `SDM_ID_ALL); // RULE_04
        `SDM_ADDR_TRIG_CFG: err_set = ~trig_ok; // RULE_03
        default:            err_set = 1'b0;
      endcase
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst)
      err_reg <= 1'b0;
    else if (err_set)
      err_reg <= 1'b1;
    else if (wr_fire && avs_address == `SDM_ADDR_STATUS && avs_writedata[0])
      err_reg <= 1'b0;
  end

  always @* begin
    rd_next = 32'h00000000;
    case (avs_address)
      `SDM_ADDR_SW_STATE: rd_next = switch_closed;
      `SDM_ADDR_QSEL:     rd_next = {26'h0000000, qsel_reg};
      `SDM_ADDR_QDATA: begin
        rd_next[0] = switch_closed[qsel_reg[4:0]];
        rd_next[7] = q_single;
        if (q_sb != 4'hf) begin
          rd_next[2:1] = open_mode_reg[q_sb];
          rd_next[4:3] = closed_mode_reg[q_sb];
          rd_next[5]   = host_sb_level[q_sb];
          rd_next[6]   = drive_sb_level[q_sb];
        end
      end
      `SDM_ADDR_TRIG_CFG: rd_next = {17'h00000, trig_cfg_reg};
      `SDM_ADDR_STATUS:   rd_next = {28'h0000000, tout_mon, tin_mon,
                                     (MON_SUPPORTED != 0), err_reg};
      default:            rd_next = 32'h00000000;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst)
      avs_readdata <= 32'h00000000;
    else if (rd_fire)
      avs_readdata <= rd_next;
  end

  // Pin drive follows the open or closed setting of each sideband pin.
  always @* begin
    host_oe_next  = 9'h000;
    host_o_next   = 9'h000;
    drive_oe_next = 9'h000;
    drive_o_next  = 9'h000;
    req_mode      = `SDM_DRV_NONE;
    dmap          = 4'h0;
    for (j = 0; j < 9; j = j + 1) begin
      req_mode = switch_closed[22 + j] ? closed_mode_reg[j] : open_mode_reg[j]; // RULE_18
      dmap = drive_map(j[3:0], req_mode);
      host_oe_next[j]  = dmap[3];
      host_o_next[j]   = dmap[2];
      drive_oe_next[j] = dmap[1];
      drive_o_next[j]  = dmap[0];
    end
  end

  // The pin drive is registered so that no decode glitch reaches a pin.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      host_drv_o   <= 9'h000;
      host_drv_oe  <= 9'h000;
      drive_drv_o  <= 9'h000;
      drive_drv_oe <= 9'h000;
    end else begin
      host_drv_oe  <= host_oe_next;
      host_drv_o   <= host_o_next;
      drive_drv_oe <= drive_oe_next;
      drive_drv_o  <= drive_o_next;
    end
  end

  // Trigger lines are only driven while their mode selects monitoring.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      trig_in_o   <= 1'b0;
      trig_in_oe  <= 1'b0;
      trig_out_o  <= 1'b0;
      trig_out_oe <= 1'b0;
    end else begin
      trig_in_oe  <= tin_mon; // RULE_01 RULE_02
      trig_out_oe <= tout_mon; // RULE_01
      trig_in_o   <= tin_mon &
                     (tin_side ? drive_sb_level[tin_sel] : host_sb_level[tin_sel]); // RULE_01
      trig_out_o  <= tout_mon &
                     (tout_side ? drive_sb_level[tout_sel] : host_sb_level[tout_sel]); // RULE_01
    end
  end

endmodule

// ==== bench/sdm_select_chk.sv ====
/* Checker for sdm_select: pin drive limits, trigger monitor and switch updates.
   Bound to every sdm_select instance; it sees that module's ports only. */
`include "sdm_regs.vh"
module sdm_select_chk #(
  parameter MON_SUPPORTED = 1
) (
  input logic        clock,
  input logic        rst,
  input logic [7:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic [8:0]  host_sb_level,
  input logic [8:0]  drive_sb_level,
  input logic [31:0] switch_closed,
  input logic [8:0]  host_drv_o,
  input logic [8:0]  host_drv_oe,
  input logic [8:0]  drive_drv_o,
  input logic [8:0]  drive_drv_oe,
  input logic        trig_in_o,
  input logic        trig_in_oe,
  input logic        trig_out_o,
  input logic        trig_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] cfg_reg;
  wire wr_ok = avs_write && !avs_waitrequest;
  wire in_mon = cfg_reg[1:0] == `SDM_MODE_SIDEBAND && MON_SUPPORTED != 0;
  wire out_mon = cfg_reg[9:8] == `SDM_MODE_SIDEBAND && MON_SUPPORTED != 0;
  wire in_lvl = cfg_reg[6] ? drive_sb_level[cfg_reg[5:2]] : host_sb_level[cfg_reg[5:2]];
  wire out_lvl = cfg_reg[14] ? drive_sb_level[cfg_reg[13:10]] : host_sb_level[cfg_reg[13:10]];
  // Shadow of the accepted trigger configuration; refused writes leave it alone.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cfg_reg <= 15'h0000;
    else if (wr_ok && avs_address == `SDM_ADDR_TRIG_CFG && avs_writedata[5:2] <= `SDM_SB_LAST
             && avs_writedata[13:10] <= `SDM_SB_LAST) cfg_reg <= avs_writedata[14:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("wait state count wrong");
  chk_trig_mode: assert property (trig_in_oe == $past(in_mon) && trig_out_oe == $past(out_mon))
    else $error("trigger drive enable wrong");
  chk_trig_level: assert property ((!trig_in_oe || trig_in_o == $past(in_lvl)) && (!trig_out_oe
    || trig_out_o == $past(out_lvl))) else $error("trigger level wrong");
  chk_sw_cause: assert property ($changed(switch_closed) |-> $past(wr_ok && avs_address ==
    `SDM_ADDR_SW_CMD)) else $error("switch changed without command");
  chk_presence_pin: assert property (!drive_drv_oe[0] && !(host_drv_oe[0] && host_drv_o[0]))
    else $error("presence drive wrong");
  chk_bus_reset: assert property (!host_drv_oe[3]) else $error("bus reset host driven");
  chk_drive_only: assert property (host_drv_oe[8:7] == 2'b00 && !host_drv_oe[1])
    else $error("host side driven");
  chk_shared_low: assert property (!host_drv_oe[2] && !(drive_drv_oe[2] && drive_drv_o[2]))
    else $error("shared reset drive wrong");
  chk_indicator_pin: assert property (!drive_drv_oe[6] && !(host_drv_oe[6] && host_drv_o[6]))
    else $error("indicator drive wrong");
  chk_no_bus_drive: assert property (host_drv_oe[5:4] == 2'b00 && drive_drv_oe[5:4] == 2'b00)
    else $error("bus data or clock driven");
  cover property (trig_in_oe && trig_out_oe);
  cover property (host_drv_oe[0]);
  cover property (drive_drv_oe[2] && drive_drv_oe[8]);
endmodule
bind sdm_select sdm_select_chk #(.MON_SUPPORTED(MON_SUPPORTED)) u_chk (.clock(clock), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .host_sb_level(host_sb_level), .drive_sb_level(drive_sb_level), .switch_closed(switch_closed),
  .host_drv_o(host_drv_o), .host_drv_oe(host_drv_oe), .drive_drv_o(drive_drv_o),
  .drive_drv_oe(drive_drv_oe), .trig_in_o(trig_in_o), .trig_in_oe(trig_in_oe),
  .trig_out_o(trig_out_o), .trig_out_oe(trig_out_oe));

// ==== bench/sdm_pins_model.sv ====
/* Host slot and drive pins: each wire shows the block's drive when enabled,
   else the level its own side puts on it. Assumes levels given by the bench. */
module sdm_pins_model (
  input  wire [8:0] host_drv_o,
  input  wire [8:0] host_drv_oe,
  input  wire [8:0] drive_drv_o,
  input  wire [8:0] drive_drv_oe,
  input  wire [8:0] nat_host,
  input  wire [8:0] nat_drive,
  input  wire       trig_in_o,
  input  wire       trig_in_oe,
  output wire [8:0] host_sb_level,
  output wire [8:0] drive_sb_level,
  output wire       trig_in_line
);
  timeunit 1ns;
  timeprecision 1ps;
  assign host_sb_level = (host_drv_oe & host_drv_o) | (~host_drv_oe & nat_host);
  assign drive_sb_level = (drive_drv_oe & drive_drv_o) | (~drive_drv_oe & nat_drive);
  // The far side never drives the trigger line; a pull-up holds it when idle.
  assign trig_in_line = trig_in_oe ? trig_in_o : 1'b1;
endmodule

// ==== bench/tb.sv ====
/* Self-checking bench for sdm_select: reset state, switch groups, pin drive and
   trigger monitor. Assumes the pin model and the bound checker are compiled. */
`include "sdm_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, cl, s;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, switch_closed, q, sw;
  logic        avs_waitrequest, trig_in_o, trig_in_oe, trig_out_o, trig_out_oe, trig_in_line;
  logic [8:0]  host_sb_level, drive_sb_level, host_drv_o, host_drv_oe, drive_drv_o, drive_drv_oe;
  logic [8:0]  nat_host = 9'h000, nat_drive = 9'h000;
  logic [5:0]  id;
  logic [3:0]  e, md;
  logic [14:0] cfg;
  int          k, i, c, n_mismatch = 0, checked = 0;
  always #5 clock = ~clock;
  sdm_select dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .host_sb_level(host_sb_level),
    .drive_sb_level(drive_sb_level), .switch_closed(switch_closed), .host_drv_o(host_drv_o),
    .host_drv_oe(host_drv_oe), .drive_drv_o(drive_drv_o), .drive_drv_oe(drive_drv_oe),
    .trig_in_o(trig_in_o), .trig_in_oe(trig_in_oe), .trig_out_o(trig_out_o),
    .trig_out_oe(trig_out_oe));
  sdm_pins_model pins (.host_drv_o(host_drv_o), .host_drv_oe(host_drv_oe),
    .drive_drv_o(drive_drv_o), .drive_drv_oe(drive_drv_oe), .nat_host(nat_host),
    .nat_drive(nat_drive), .trig_in_o(trig_in_o), .trig_in_oe(trig_in_oe),
    .host_sb_level(host_sb_level), .drive_sb_level(drive_sb_level), .trig_in_line(trig_in_line));
  task automatic close_out;
    $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon transfer; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      close_out();
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function automatic logic [31:0] grp(input logic [5:0] g);
    case (g)
      6'h20: return 32'hffffffff;
      6'h21, 6'h22, 6'h23, 6'h24: return 32'hf << (4 * (g - 6'h21));
      6'h25: return 32'h00030000;
      6'h26: return 32'h0000ffff;
      6'h27: return 32'h0e000000;
      6'h28: return 32'h000c0000;
      6'h29: return 32'h00300000;
      6'h2a: return 32'h8e000000;
      6'h2b: return 32'h008c00ff;
      6'h2c: return 32'h0130ff00;
      6'h2d: return 32'h000000ff;
      6'h2e: return 32'h0000ff00;
      default: return (g < 6'h20) ? 32'h1 << g : 32'h0;
    endcase
  endfunction
  // Expected {host oe, host level, drive oe, drive level} for one pin and mode.
  function automatic logic [3:0] drv(input int p, input logic [1:0] m);
    case (p)
      0, 6: return {m == `SDM_DRV_LOW, 3'b000};
      1, 3, 7, 8: return {2'b00, m == `SDM_DRV_LOW || m == `SDM_DRV_HIGH, m == `SDM_DRV_HIGH};
      2: return {2'b00, m == `SDM_DRV_LOW, 1'b0};
      default: return 4'h0;
    endcase
  endfunction
  initial begin
    void'($urandom(74));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    bus(0, `SDM_ADDR_SW_STATE, 0, q);
    check(q, `SDM_SW_RESET);
    bus(0, `SDM_ADDR_STATUS, 0, q);
    check(q, 32'h2);
    bus(1, 8'h1c, 32'hffffffff, q);
    bus(0, 8'h1c, 0, q);
    check(q, 32'h0);
    $display("test reset done");
    sw = 32'h0;
    for (k = 0; k < 60; k++) begin
      id = (k < 15) ? 6'(32 + k) : 6'($urandom);
      cl = 1'($urandom);
      bus(1, `SDM_ADDR_SW_CMD, {23'h0, cl, 2'h0, id}, q);
      if (id <= 6'h2e) sw = cl ? sw | grp(id) : sw & ~grp(id);
      bus(0, `SDM_ADDR_SW_STATE, 0, q);
      check(q, sw);
    end
    bus(1, `SDM_ADDR_SW_CMD, 32'h3f, q);
    bus(0, `SDM_ADDR_STATUS, 0, q);
    check(q, 32'h3);
    $display("test switch done");
    for (k = 0; k < 36; k++) begin
      i = k % 9;
      md = (i == 4 || i == 5) ? 4'h0 : {2'($urandom), 2'(k / 9)};
      nat_host <= 9'($urandom);
      nat_drive <= 9'($urandom);
      bus(1, `SDM_ADDR_DRV_CMD, {20'h0, md, 2'h0, 6'(22 + i)}, q);
      for (c = 0; c < 2; c++) begin
        bus(1, `SDM_ADDR_SW_CMD, {23'h0, c[0], 2'h0, 6'(22 + i)}, q);
        repeat (2) @(negedge clock);
        e = drv(i, c[0] ? md[3:2] : md[1:0]);
        check(32'({host_drv_oe[i], host_drv_oe[i] & host_drv_o[i], drive_drv_oe[i],
          drive_drv_oe[i] & drive_drv_o[i]}), 32'(e));
        bus(1, `SDM_ADDR_QSEL, 32'(22 + i), q);
        bus(0, `SDM_ADDR_QDATA, 0, q);
        check(q, {24'h0, 1'b1, e[1] ? e[0] : nat_drive[i], e[3] ? e[2] : nat_host[i], md,
          c[0]});
      end
    end
    bus(1, `SDM_ADDR_QSEL, 32'h20, q);
    bus(0, `SDM_ADDR_QSEL, 0, q);
    check(q, 32'h1e);
    bus(1, `SDM_ADDR_STATUS, 32'h1, q);
    $display("test drive done");
    for (k = 0; k < 9; k++) begin
      s = 1'($urandom);
      cfg = {s, 4'(8 - k), 2'h3, 1'b0, ~s, 4'(k), 2'h3};
      bus(1, `SDM_ADDR_TRIG_CFG, 32'(cfg), q);
      for (c = 0; c < 2; c++) begin
        @(posedge clock);
        nat_host <= 9'($urandom);
        nat_drive <= 9'($urandom);
        repeat (2) @(negedge clock);
        check(32'({trig_in_oe, trig_in_o, trig_out_oe, trig_out_o}), 32'({1'b1, s ?
          host_sb_level[k] : drive_sb_level[k], 1'b1, s ? drive_sb_level[8 - k] :
          host_sb_level[8 - k]}));
      end
    end
    bus(1, `SDM_ADDR_TRIG_CFG, 32'h27, q);
    bus(0, `SDM_ADDR_TRIG_CFG, 0, q);
    check(q, 32'(cfg));
    bus(0, `SDM_ADDR_STATUS, 0, q);
    check(q, 32'hf);
    bus(1, `SDM_ADDR_TRIG_CFG, 32'h0, q);
    repeat (2) @(negedge clock);
    check(32'({trig_in_oe, trig_out_oe, trig_in_line}), 32'h1);
    $display("test trigger done");
    close_out();
  end
endmodule
